// [bench/angle_count_control_tb.sv]
`timescale 1ns/1ns
module angle_count_control_tb;
    import angle_pkg::*;
    typedef struct packed {logic [7:0] a; logic wr; logic [31:0] d; logic [31:0] e;} row_t;
    logic clk_in, reset_n_in, ce_in, tick_en, tooth_req, tb1_tick, tooth_pin;
    logic hsel, hwrite, hreadyout, hresp, angle_tick, ch0_edge;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic [ANGLE_W-1:0] angle;
    mode_t mode;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int gap = 0;
    int last_gap = 0;
    int ch0_count = 0;
    row_t rows [10] = '{
        '{ADDR_CTRL, 1'b0, 32'h0, 32'h0}, '{ADDR_TPR, 1'b0, 32'h0, 32'h0},
        '{ADDR_TRR, 1'b0, 32'h0, 32'h00000200}, '{ADDR_STATUS, 1'b0, 32'h0, 32'h00000001},
        '{ADDR_ANGLE, 1'b0, 32'h0, 32'h0}, '{8'h14, 1'b0, 32'h0, 32'h0},
        '{8'h14, 1'b1, 32'hFFFFFFFF, 32'h0}, '{ADDR_TRR, 1'b1, 32'hFFABCDEF, 32'h00ABCDEF},
        '{ADDR_TPR, 1'b1, 32'hFFFFFFFF, 32'h001303FF}, '{ADDR_CTRL, 1'b1, 32'h2, 32'h0}};

    tooth_source partner (.clk_in(clk_in), .reset_n_in(reset_n_in), .tick_en_in(tick_en),
        .tooth_req_in(tooth_req), .tb1_tick_out(tb1_tick), .tooth_out(tooth_pin));

    angle_count_control DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
        .tb1_tick_in(tb1_tick), .tooth_input_pin_in(tooth_pin), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hreadyout), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .hrdata_out(hrdata), .angle_time_base_out(angle),
        .angle_tick_out(angle_tick), .ch0_edge_out(ch0_edge), .mode_out(mode));

    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // values seen here are those from before the edge, so no race
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        gap <= angle_tick ? 1 : gap + 1;
        if (angle_tick)
            last_gap <= gap;
        if (ch0_edge)
            ch0_count <= ch0_count + 1;
        if (cycles == 20000)
        begin
            fail_count = fail_count + 1;
            results();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic ahb_cycle(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        ahb_cycle(a, 1'b1, d);
    endtask

    task automatic ahb_read(input logic [7:0] a);
        ahb_cycle(a, 1'b0, 32'h0);
    endtask

    task automatic wait_mode(input mode_t m);
        int n;
        n = 0;
        while (mode !== m && n < 400)
        begin
            @(posedge clk_in);
            n = n + 1;
        end
        check("mode", 32'(mode), 32'(m));
    endtask

    task automatic tooth();
        tooth_req <= 1'b1;
        @(posedge clk_in);
        tooth_req <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        reset_n_in = 1'b0;
        ce_in = 1'b1;
        tick_en = 1'b0;
        tooth_req = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        check("reset mode", 32'(mode), 32'(MODE_NORMAL));
        ce_in <= 1'b0;
        @(posedge clk_in);
        check("hreadyout", 32'(hreadyout), 32'h0);
        ce_in <= 1'b1;
        @(posedge clk_in);
        foreach (rows[i])
        begin
            if (rows[i].wr)
                ahb_write(rows[i].a, rows[i].d);
            ahb_read(rows[i].a);
            check("register", rd, rows[i].e);
            check("hresp", 32'(hresp), 32'h0);
        end
        // deceleration: estimated end comes first, then the tooth
        ahb_write(ADDR_TRR, 32'h00000200);
        ahb_write(ADDR_TPR, 32'h00000002);
        // reinit too, so the prescaler reloads from the new rate
        ahb_write(ADDR_CTRL, 32'h00000003);
        tick_en <= 1'b1;
        wait_mode(MODE_HALT);
        tick_en <= 1'b0;
        check("angle at halt", 32'(angle), 32'h2);
        repeat (10) @(posedge clk_in);
        check("angle held", 32'(angle), 32'h2);
        ahb_read(ADDR_STATUS);
        check("status halt", rd, 32'h00020002);
        tooth();
        wait_mode(MODE_NORMAL);
        check("angle resumed", 32'(angle), 32'h3);
        ahb_read(ADDR_STATUS);
        check("status resumed", rd, 32'h00000101);
        check("channel edges", 32'(ch0_count), 32'h1);
        // acceleration: tooth at count 0, writes and noise during the run
        tooth();
        wait_mode(MODE_HIGH);
        ahb_write(ADDR_TPR, 32'h00000005);
        ahb_write(ADDR_TRR, 32'h00000400);
        repeat (3) @(posedge clk_in);
        tooth();
        check("noise tooth", 32'(mode), 32'(MODE_HIGH));
        wait_mode(MODE_NORMAL);
        check("high rate spacing", 32'(last_gap), 32'h8);
        check("angle after run", 32'(angle), 32'h6);
        ahb_read(ADDR_STATUS);
        check("status after run", rd, 32'h00000201);
        check("channel edges", 32'(ch0_count), 32'h3);
        tick_en <= 1'b1;
        wait_mode(MODE_HALT);
        tick_en <= 1'b0;
        check("new ticks used", 32'(angle), 32'h0B);
        // restart, then one dummy tooth followed by the last tooth
        ahb_write(ADDR_CTRL, 32'h00000003);
        // strobe acts one edge after the write lands
        repeat (2) @(posedge clk_in);
        check("reinit angle", 32'(angle), 32'h0);
        check("reinit mode", 32'(mode), 32'(MODE_NORMAL));
        ahb_write(ADDR_TRR, 32'h00000200);
        ahb_write(ADDR_TPR, 32'h00110001);
        tick_en <= 1'b1;
        wait_mode(MODE_HALT);
        tick_en <= 1'b0;
        check("angle with dummy", 32'(angle), 32'h3);
        ahb_read(ADDR_TPR);
        check("dummy count left", rd, 32'h00100001);
        tooth();
        wait_mode(MODE_NORMAL);
        check("angle wrapped", 32'(angle), 32'h0);
        // coincident tooth: zero ticks ends the estimate at once
        ahb_write(ADDR_CTRL, 32'h00000000);
        ahb_write(ADDR_TPR, 32'h00000000);
        fork
            ahb_write(ADDR_CTRL, 32'h00000001);
            begin
                @(posedge clk_in);
                tooth_req <= 1'b1;
                @(posedge clk_in);
                tooth_req <= 1'b0;
            end
        join
        repeat (2) @(posedge clk_in);
        check("coincide mode", 32'(mode), 32'(MODE_NORMAL));
        check("coincide angle", 32'(angle), 32'h1);
        ahb_read(ADDR_STATUS);
        check("coincide status", rd, 32'h00000302);
        // reset in mid-run
        reset_n_in <= 1'b0;
        @(posedge clk_in);
        check("reset angle", 32'(angle), 32'h0);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        ahb_read(ADDR_STATUS);
        check("status after reset", rd, 32'h00000001);
        results();
    end
endmodule

// [bench/tooth_source.sv]
`timescale 1ns/1ns
module tooth_source
(
    input wire logic clk_in, // system clock
    input wire logic reset_n_in, // async reset
    input wire logic tick_en_in, // run the primary time base
    input wire logic tooth_req_in, // one-cycle request for a tooth
    output logic tb1_tick_out, // count pulse, every second clock
    output logic tooth_out // filtered tooth level
);
    logic [2:0] width_q;

    // filtered line is always driven, so a plain level is enough
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tb1_tick_out <= 1'b0;
            width_q <= 3'h0;
        end
        else
        begin
            tb1_tick_out <= tick_en_in & ~tb1_tick_out;
            if (tooth_req_in)
                width_q <= 3'h4;
            else if (width_q != 3'h0)
                width_q <= width_q - 3'h1;
        end
    end

    assign tooth_out = (width_q != 3'h0);
endmodule

// [rtl/angle_count_control.sv]
`timescale 1ns/1ns
module angle_count_control
(
    input wire logic clk_in, // system clock
    input wire logic reset_n_in, // async reset
    input wire logic ce_in, // clock enable
    input wire logic tb1_tick_in, // primary time base count pulse
    input wire logic tooth_input_pin_in, // filtered tooth level
    input wire logic hsel_in, // ahb select
    input wire logic [7:0] haddr_in, // ahb address
    input wire logic [1:0] htrans_in, // ahb transfer type
    input wire logic hwrite_in, // ahb write
    input wire logic [2:0] hsize_in, // ahb size
    input wire logic [31:0] hwdata_in, // ahb write data
    input wire logic hready_in, // ahb bus ready
    output logic hreadyout_out, // ahb slave ready
    output logic hresp_out, // ahb response
    output logic [31:0] hrdata_out, // ahb read data
    output logic [angle_pkg::ANGLE_W-1:0] angle_time_base_out, // angle count
    output logic angle_tick_out, // tick counted
    output logic ch0_edge_out, // channel 0 transition
    output angle_pkg::mode_t mode_out // current mode
);
    import angle_pkg::*;

    logic enable_q, reinit_q, tooth_prev_q, ch0_edge_q, tick_seen_q, hold_q, wr_pend_q;
    tpr_t tpr_q, tmp_q;
    trr_t trr_q;
    mode_t mode_q;
    logic [TICKS_W-1:0] tick_cnt_q;
    logic [TOOTH_W-1:0] tooth_cnt_q;
    logic [ANGLE_W-1:0] angle_q;
    logic [TRR_INT_W-1:0] presc_q;
    logic [TRR_FRAC_W-1:0] frac_acc_q;
    logic [HR_CNT_W-1:0] hr_cnt_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;

    tpr_t act;
    logic tooth_edge, end_now, norm_tick, hr_tick, tick, coincide, enter_high, dummy_norm;
    logic enter_halt, halt_release, hr_end, hr_dummy, hr_exit, advance, reset_angle, count;
    logic addr_ok;
    logic [31:0] rd_d;
    logic [TRR_FRAC_W:0] frac_sum;
    logic [TRR_INT_W-1:0] reload;

    // bus side: ready follows ce_in, so wait states while ce_in is low, always OKAY
    assign hreadyout_out = ce_in;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_q;
    assign addr_ok = hsel_in && htrans_in[1] && hready_in;

    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (haddr_in == ADDR_CTRL)
            rd_d[CTRL_ENABLE_BIT] = enable_q;
        else if (haddr_in == ADDR_TPR)
        begin
            rd_d[TPR_TICKS_LSB +: TICKS_W] = tpr_q.ticks;
            rd_d[TPR_MISS_LSB +: 2] = tpr_q.miss;
            rd_d[TPR_LAST_BIT] = tpr_q.last;
        end
        else if (haddr_in == ADDR_TRR)
            rd_d[TRR_W-1:0] = trr_q;
        else if (haddr_in == ADDR_STATUS)
        begin
            rd_d[STAT_MODE_LSB +: 3] = mode_q;
            rd_d[STAT_TOOTH_LSB +: TOOTH_W] = tooth_cnt_q;
            rd_d[STAT_TICK_LSB +: TICKS_W] = tick_cnt_q;
        end
        else if (haddr_in == ADDR_ANGLE)
            rd_d[ANGLE_W-1:0] = angle_q;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end
        else if (ce_in)
        begin
            wr_pend_q <= addr_ok && hwrite_in;
            if (addr_ok)
                wr_addr_q <= haddr_in;
            if (addr_ok && !hwrite_in)
                hrdata_q <= rd_d;
        end
    end

    // reinit is a self-clearing strobe
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            enable_q <= CTRL_ENABLE_RESET;
            reinit_q <= 1'b0;
        end
        else if (ce_in)
        begin
            reinit_q <= wr_pend_q && (wr_addr_q == ADDR_CTRL) && hwdata_in[CTRL_REINIT_BIT];
            if (wr_pend_q && (wr_addr_q == ADDR_CTRL))
                enable_q <= hwdata_in[CTRL_ENABLE_BIT];
        end
    end

    // software write of the tooth program wins over the hardware decrement
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tpr_q <= TPR_RESET;
            trr_q <= TRR_RESET;
        end
        else if (ce_in)
        begin
            if (wr_pend_q && (wr_addr_q == ADDR_TPR))
            begin
                tpr_q.ticks <= hwdata_in[TPR_TICKS_LSB +: TICKS_W];
                tpr_q.miss <= hwdata_in[TPR_MISS_LSB +: 2];
                tpr_q.last <= hwdata_in[TPR_LAST_BIT];
            end
            else if (dummy_norm)
                tpr_q.miss <= tpr_q.miss - 2'h1;
            if (wr_pend_q && (wr_addr_q == ADDR_TRR))
                trr_q <= hwdata_in[TRR_W-1:0];
        end
    end

    // high rate runs on the frozen copy, so live ticks writes wait
    assign act = (mode_q == MODE_HIGH) ? tmp_q : tpr_q;
    assign tooth_edge = enable_q && tooth_input_pin_in && !tooth_prev_q;
    assign end_now = (tick_cnt_q == act.ticks);
    assign hr_tick = (mode_q == MODE_HIGH) && (hr_cnt_q == '0);
    assign norm_tick = enable_q && (mode_q != MODE_HIGH) && tb1_tick_in && !hold_q
        && (presc_q == '0);
    assign tick = (mode_q == MODE_HIGH) ? hr_tick : norm_tick;
    assign coincide = (mode_q == MODE_NORMAL) && tooth_edge && end_now;
    assign enter_high = (mode_q == MODE_NORMAL) && tooth_edge && !end_now;
    assign dummy_norm = enable_q && (mode_q == MODE_NORMAL) && !tooth_edge && end_now
        && (tpr_q.miss != 2'h0);
    assign enter_halt = enable_q && (mode_q == MODE_NORMAL) && !tooth_edge && end_now
        && (tpr_q.miss == 2'h0);
    assign halt_release = (mode_q == MODE_HALT) && tooth_edge;
    assign hr_end = (mode_q == MODE_HIGH) && end_now;
    assign hr_dummy = hr_end && (tmp_q.miss != 2'h0);
    assign hr_exit = hr_end && (tmp_q.miss == 2'h0);
    assign advance = coincide || dummy_norm || halt_release || hr_end;
    assign reset_angle = ((coincide || halt_release) && tpr_q.last && (tpr_q.miss == 2'h0))
        || (hr_exit && tmp_q.last);
    assign count = tick && !end_now && (mode_q != MODE_HALT);
    assign frac_sum = {1'b0, frac_acc_q} + {1'b0, trr_q.frac};
    assign reload = (trr_q.int_part == '0) ? '0 : trr_q.int_part - 15'h0001;

    // normal tick generator, reloaded from the latest rate on each tick
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            presc_q <= '0;
            frac_acc_q <= '0;
            hold_q <= 1'b0;
        end
        else if (ce_in)
        begin
            if (reinit_q || hr_exit)
            begin
                presc_q <= reload;
                frac_acc_q <= '0;
                hold_q <= 1'b0;
            end
            else if (enable_q && (mode_q != MODE_HIGH) && tb1_tick_in)
            begin
                if (hold_q)
                    hold_q <= 1'b0;
                else if (presc_q == '0)
                begin
                    presc_q <= reload;
                    frac_acc_q <= frac_sum[TRR_FRAC_W-1:0];
                    hold_q <= frac_sum[TRR_FRAC_W];
                end
                else
                    presc_q <= presc_q - 15'h0001;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            hr_cnt_q <= HR_PRELOAD;
        end
        else if (ce_in)
        begin
            if (enter_high || hr_cnt_q == '0)
                hr_cnt_q <= HR_PRELOAD;
            else if (mode_q == MODE_HIGH)
                hr_cnt_q <= hr_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tooth_prev_q <= 1'b0;
            ch0_edge_q <= 1'b0;
        end
        else if (ce_in)
        begin
            tooth_prev_q <= tooth_input_pin_in;
            ch0_edge_q <= tooth_edge;
        end
    end

    // count control: mode, tick and tooth counters, angle accumulator
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            mode_q <= MODE_NORMAL;
            tick_cnt_q <= '0;
            tooth_cnt_q <= '0;
            angle_q <= '0;
            tmp_q <= TPR_RESET;
            tick_seen_q <= 1'b0;
        end
        else if (ce_in)
        begin
            tick_seen_q <= count;
            if (reinit_q || !enable_q)
            begin
                mode_q <= MODE_NORMAL;
                tick_cnt_q <= '0;
                if (reinit_q)
                begin
                    tooth_cnt_q <= '0;
                    angle_q <= '0;
                end
            end
            else
            begin
                if (enter_high)
                begin
                    mode_q <= MODE_HIGH;
                    tmp_q <= tpr_q;
                end
                else if (enter_halt)
                    mode_q <= MODE_HALT;
                else if (halt_release || hr_exit)
                    mode_q <= MODE_NORMAL;
                if (hr_dummy)
                    tmp_q.miss <= tmp_q.miss - 2'h1;
                if (advance)
                begin
                    tick_cnt_q <= '0;
                    tooth_cnt_q <= tooth_cnt_q + 8'h01;
                    angle_q <= reset_angle ? '0 : angle_q + 24'h000001;
                end
                else if (count)
                begin
                    tick_cnt_q <= tick_cnt_q + 10'h001;
                    angle_q <= angle_q + 24'h000001;
                end
            end
        end
    end

    assign angle_time_base_out = angle_q;
    assign angle_tick_out = tick_seen_q;
    assign ch0_edge_out = ch0_edge_q;
    assign mode_out = mode_q;

    AST_ACCUM: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (angle_q != $past(angle_q)) |-> (angle_q == $past(angle_q) + 24'h000001)
        || (angle_q == '0))
        else $error("angle jumped by more than one");
    AST_CH0: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && tooth_edge) |=> ch0_edge_out)
        else $error("filtered tooth edge not passed to channel 0");
    AST_COINCIDE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && coincide && !reinit_q) |=> (mode_q == MODE_NORMAL) && (tick_cnt_q == '0)
        && (tooth_cnt_q == $past(tooth_cnt_q) + 8'h01))
        else $error("coincident tooth did not advance");
    AST_HALT_ENTRY: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && enter_halt && !reinit_q) |=> (mode_q == MODE_HALT)
        ##0 ($stable(angle_q) && $stable(tooth_cnt_q)))
        else $error("halt not entered at estimated end");
    AST_HALT_RELEASE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && halt_release && !reinit_q) |=> (mode_q == MODE_NORMAL)
        && (tick_cnt_q == '0) && (tooth_cnt_q == $past(tooth_cnt_q) + 8'h01))
        else $error("halt release wrong");
    AST_ENTER_HIGH: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && enter_high && !reinit_q) |=> (mode_q == MODE_HIGH) && (tmp_q == $past(tpr_q)))
        else $error("high rate entry without copy");
    AST_HR_FIRST: assert property (@(posedge clk_in) disable iff (!reset_n_in || !ce_in)
        (enter_high && !reinit_q) |=> !hr_tick [*7] ##1 (hr_tick || mode_q != MODE_HIGH))
        else $error("first high rate tick not eight clocks after entry");
    AST_HR_NOISE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && mode_q == MODE_HIGH && !hr_end && !reinit_q && enable_q)
        |=> (mode_q == MODE_HIGH))
        else $error("tooth during high rate changed mode");
    AST_HR_EXIT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && hr_exit && !reinit_q && enable_q) |=> (mode_q == MODE_NORMAL)
        && (tick_cnt_q == '0))
        else $error("high rate end did not return to normal");
    AST_DUMMY: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (ce_in && dummy_norm && !reinit_q) |=> (mode_q == MODE_NORMAL)
        && (tpr_q.miss == $past(tpr_q.miss) - 2'h1 || $past(wr_pend_q)))
        else $error("dummy tooth not inserted");
endmodule

// [rtl/angle_pkg.sv]
package angle_pkg;
    localparam int TICKS_W = 10;
    localparam int TRR_INT_W = 15;
    localparam int TRR_FRAC_W = 9;
    localparam int TRR_W = 24;
    localparam int ANGLE_W = 24;
    localparam int TOOTH_W = 8;
    localparam int HR_CNT_W = 3;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TPR = 8'h04;
    localparam logic [7:0] ADDR_TRR = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_ANGLE = 8'h10;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_REINIT_BIT = 1;
    localparam int TPR_TICKS_LSB = 0;
    localparam int TPR_MISS_LSB = 16;
    localparam int TPR_LAST_BIT = 20;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_TOOTH_LSB = 8;
    localparam int STAT_TICK_LSB = 16;

    // high-rate tick every eight system clocks; preload gives the full eight
    localparam logic [HR_CNT_W-1:0] HR_PRELOAD = 3'h7;

    typedef struct packed {
        logic last;
        logic [1:0] miss;
        logic [TICKS_W-1:0] ticks;
    } tpr_t;

    typedef struct packed {
        logic [TRR_INT_W-1:0] int_part;
        logic [TRR_FRAC_W-1:0] frac;
    } trr_t;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_HALT = 3'b010,
        MODE_HIGH = 3'b100
    } mode_t;

    localparam tpr_t TPR_RESET = '{last: 1'b0, miss: 2'h0, ticks: 10'h000};
    localparam trr_t TRR_RESET = '{int_part: 15'h0001, frac: 9'h000};
    localparam logic CTRL_ENABLE_RESET = 1'b0;
endpackage
